// *** eesb_map.vh ***
`ifndef EESB_MAP_VH
`define EESB_MAP_VH
`define EESB_ADDR_W          8
`define EESB_ADDR_STATUS     8'h70
`define EESB_ADDR_GAIN       8'h72
`define EESB_STATUS_RESET    8'h00
`define EESB_BIT_CFG         0
`define EESB_BIT_OFF         1
`define EESB_BIT_ST          2
`define EESB_BIT_EXT         3
`define EESB_BIT_AMIN        4
`define EESB_BIT_AMAX        5
`define EESB_BIT_MTI         6
`define EESB_BIT_MT          7
`define EESB_PIN_SETTLE      3'd5
`endif

// *** eesb_sync.v ***
`timescale 1ns/1ps
`default_nettype none
module eesb_sync (
  input  wire clk,
  input  wire arst_n,
  input  wire ce,
  input  wire din,
  output reg  dout
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  // three stages, change accepted when stages two and three agree
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      dout <= 1'b1;
    end else if (ce) begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule
`default_nettype wire

// *** eesb_status_bank.v ***
`timescale 1ns/1ps
`default_nettype none
`include "eesb_map.vh"
module eesb_status_bank (
  input  wire       clk,
  input  wire       arst_n,
  input  wire       ce,
  input  wire       rd_en,
  input  wire [7:0] rd_addr,
  output reg  [7:0] rd_data,
  input  wire       pos_req,
  output wire       pos_err_bit,
  input  wire       angle_valid,
  input  wire       cfg_loading,
  input  wire       cfg_crc_err,
  input  wire       off_crc_err,
  input  wire       amp_high,
  input  wire       amp_low,
  input  wire       mt_input_err,
  input  wire       mt_internal_err,
  input  wire [3:0] coarse_gain_setting,
  input  wire [3:0] fine_gain_setting,
  input  wire       error_pin_n_in,
  output wire       error_pin_n_out,
  output wire       error_pin_n_oe
);
  reg  [7:0] status_q;
  reg  [7:0] status_d;
  reg  [7:0] gain_q;
  reg        drive_low_q;
  reg  [2:0] settle_q;
  wire       pin_sync;
  wire       status_rd;
  wire       ext_fault;
  wire [7:0] gain_prod;

  // product of coarse and fine gain
  function [7:0] gain_mul;
    input [3:0] a;
    input [3:0] b;
    begin
      gain_mul = a * b;
    end
  endfunction

  // error pin sampled through three flip-flops, then a filtered output flip-flop
  eesb_sync u_pin_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .ce     (ce),
    .din    (error_pin_n_in),
    .dout   (pin_sync)
  );

  // pin low from outside while we are not driving it
  // masked until our own release has passed the synchroniser
  assign ext_fault = ~pin_sync & ~drive_low_q & (settle_q == 3'd0);
  assign status_rd = rd_en && (rd_addr == `EESB_ADDR_STATUS);
  assign gain_prod = gain_mul(coarse_gain_setting, fine_gain_setting);

  // open drain: drive low during config load
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      drive_low_q <= 1'b1;
      settle_q    <= `EESB_PIN_SETTLE;
    end else if (ce) begin
      drive_low_q <= cfg_loading | cfg_crc_err;
      if (drive_low_q) begin
        settle_q <= `EESB_PIN_SETTLE;
      end else if (settle_q != 3'd0) begin
        settle_q <= settle_q - 3'd1;
      end
    end
  end
  assign error_pin_n_out = 1'b0;
  assign error_pin_n_oe  = drive_low_q;

  // sticky flags, new events win over the read clear
  always @* begin
    status_d = status_rd ? `EESB_STATUS_RESET : status_q;
    status_d[`EESB_BIT_CFG]  = status_d[`EESB_BIT_CFG]  | cfg_crc_err;
    status_d[`EESB_BIT_OFF]  = status_d[`EESB_BIT_OFF]  | off_crc_err;
    status_d[`EESB_BIT_ST]   = status_d[`EESB_BIT_ST]   | (pos_req & ~angle_valid);
    status_d[`EESB_BIT_EXT]  = status_d[`EESB_BIT_EXT]  | ext_fault;
    status_d[`EESB_BIT_AMIN] = status_d[`EESB_BIT_AMIN] | amp_low;
    status_d[`EESB_BIT_AMAX] = status_d[`EESB_BIT_AMAX] | amp_high;
    status_d[`EESB_BIT_MTI]  = status_d[`EESB_BIT_MTI]  | mt_input_err;
    status_d[`EESB_BIT_MT]   = status_d[`EESB_BIT_MT]   | mt_internal_err;
  end

  // status, gain and read data registers
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_q <= `EESB_STATUS_RESET;
      gain_q   <= 8'h00;
      rd_data  <= 8'h00;
    end else if (ce) begin
      status_q <= status_d;
      gain_q   <= gain_prod;
      if (rd_en) begin
        case (rd_addr)
          `EESB_ADDR_STATUS: rd_data <= status_q;
          `EESB_ADDR_GAIN:   rd_data <= gain_q;
          default:           rd_data <= 8'h00;
        endcase
      end
    end
  end

  // error bit of position word: any flag set
  assign pos_err_bit = |status_q;
endmodule
`default_nettype wire

// *** eesb_master.sv ***
`timescale 1ns/1ps
`default_nettype none
module eesb_master (input wire logic clk, input wire logic [7:0] rd_data,
  output var logic rd_en = 0, output var logic [7:0] rd_addr = 0);
  // one read: data a cycle later, taken once rd_en has dropped and the address has been inverted
  task automatic rd(logic [7:0] a, output logic [7:0] d);
    @(negedge clk) {rd_en, rd_addr} = {1'b1, a};
    @(negedge clk) {rd_en, rd_addr} = {1'b0, ~a};
    d = rd_data;
  endtask
endmodule
`default_nettype wire

// *** eesb_status_bank_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module eesb_status_bank_asserts (input wire logic clk, arst_n, ce, rd_en, pos_err_bit,
  input wire logic cfg_loading, error_pin_n_oe, error_pin_n_out,
  input wire logic [7:0] rd_addr, rd_data);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // taken read, status read
  wire logic r = ce & rd_en;
  wire logic s = r & rd_addr == 8'h70;
  AST_MAP: assert property (r & rd_addr != 8'h70 & rd_addr != 8'h72 |=> !rd_data)
    else $error("unmapped");
  AST_HOLD: assert property (!r |=> $stable(rd_data)) else $error("hold");
  AST_NZ: assert property (s & pos_err_bit |=> rd_data != 0) else $error("flags");
  AST_PIN: assert property (!error_pin_n_out) else $error("pin");
  AST_LOAD: assert property (ce & cfg_loading |=> error_pin_n_oe) else $error("load");
  AST_STK: assert property (pos_err_bit & !s |=> pos_err_bit) else $error("sticky");
  AST_CLR: assert property (s & !pos_err_bit |=> !rd_data) else $error("clear");
  AST_RDC: assert property (s ##1 !r [*2] |-> !rd_data || $past(pos_err_bit, 2))
    else $error("cleared read");
endmodule
`default_nettype wire

// *** tb_encoder_error_status_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_encoder_error_status_bank;
  logic clk = 0, arst_n = 0, cfg_loading = 1, ce = 1;
  logic [7:0] e = 0, d;
  int errors = 0, n_tests = 0;
  wire logic angle_valid = 0, rd_en, pos_err_bit, error_pin_n_out, error_pin_n_oe;
  // rotation direction stays normal; the bank has no such setting to drive
  wire logic [3:0] coarse_gain_setting = 4'hf, fine_gain_setting = 4'hd;
  wire logic [7:0] rd_addr, rd_data;
  wire logic cfg_crc_err = e[0], off_crc_err = e[1], pos_req = e[2], amp_low = e[4];
  wire logic amp_high = e[5], mt_input_err = e[6], mt_internal_err = e[7];
  wire logic error_pin_n_in = !(error_pin_n_oe | e[3]); // e[3] pulls low from outside
  eesb_status_bank uut (.*);
  eesb_master m (.*);
  always #12.5 clk = !clk;
  task chk(string s, logic [7:0] v, x);
    n_tests++;
    if (v !== x) begin
      errors++;
      $display("Error %s exp %h seen %h", s, x, v);
    end
  endtask
  task give_verdict;
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // each source sets its own flag, kept until read
  task t_flags;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk) e[i] = 1;
      repeat (i == 3 ? 6 : 1) @(negedge clk);
      e = 0;
      repeat (8) @(negedge clk);
      chk("err_bit", pos_err_bit, 1);
      m.rd(8'h70, d);
      chk("status", d, 8'h01 << i);
      chk("err_low", pos_err_bit, 0);
      m.rd(8'h70, d);
      chk("cleared", d, 0);
    end
  endtask
  // pin during load, gain word, unmapped read
  task t_misc;
    chk("oe", error_pin_n_oe, 1);
    cfg_loading = 0;
    repeat (9) @(negedge clk);
    m.rd(8'h70, d);
    chk("status_idle", d, 8'h00);
    // events while clock enable is low are not taken
    @(negedge clk) ce = 0;
    e = 8'h01;
    @(negedge clk) e = 0;
    ce = 1;
    repeat (2) @(negedge clk);
    chk("ce_frozen", pos_err_bit, 0);
    m.rd(8'h72, d);
    chk("gain", d, 8'hc3);
    m.rd(8'h71, d);
    chk("unmapped", d, 0);
  endtask
  initial begin
    repeat (4) @(negedge clk);
    arst_n = 1;
    t_misc;
    t_flags;
    give_verdict;
  end
  // hang guard
  initial begin
    #20us;
    errors++;
    give_verdict;
  end
endmodule
bind eesb_status_bank eesb_status_bank_asserts a (.*);
`default_nettype wire
